//--- src/ucb_uart0.v
// serial port control and data buffer: control register, data buffer,
// transmit and receive frame engines, interrupt request
// assumes the baud timer outside supplies its overflow pulse and counting tick
//
// Operation
// - mode bit 0 gives 8-bit frames, 1 gives 9-bit frames
// - control bit 6 ignores writes and always reads 1
// - 8-bit mode with filter set accepts only frames with stop bit 1
// - 9-bit mode with filter set accepts only frames with ninth bit 1
// - receive enable 0 blocks all reception, 1 allows it
// - 9-bit mode sends ninth transmit bit as ninth data bit
// - ninth receive bit takes stop bit in 8-bit, ninth bit in 9-bit
// - transmit flag set at start of stop bit
// - receive flag set when stop bit of an accepted frame is sampled
// - flags raise interrupt when enabled; only software clears them
// - data buffer write queues a byte for the transmitter; a full queue drops it
// - data buffer read returns receive latch, never transmit data
// - control register at 0x98 with single-bit read-modify-write
// - 8-bit frame is start, eight data bits lsb first, stop
// - 9-bit frame is start, eight data bits, ninth bit, stop
// - receive latch loads only while receive flag is 0
// - bit timing is overflows over two; start edge reloads receive timer
`include "ucb_consts.vh"

module ucb_uart0 (
	input wire SYS_CLK_I,
	input wire RST_I,
	input wire [7:0] SFR_ADDR_I,
	input wire SFR_WR_I,
	input wire [7:0] SFR_WDATA_I,
	input wire SFR_BIT_WR_I,
	input wire [2:0] SFR_BIT_SEL_I,
	input wire SFR_BIT_VAL_I,
	input wire SFR_RD_I,
	output wire [7:0] SFR_RDATA_O,
	output wire TX_READY_O,
	input wire TMR_RUN_I,
	input wire TMR_TICK_I,
	input wire TX_OVF_I,
	input wire [7:0] BAUD_RELOAD_VALUE_I,
	input wire SERIAL_IN_PIN_I,
	output wire SERIAL_OUT_PIN_O,
	input wire INT_EN_I,
	output wire INT_REQ_O
);
	// one-hot frame states, shared by both engines
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_START = 5'h02;
	localparam [4:0] ST_DATA = 5'h04;
	localparam [4:0] ST_NINTH = 5'h08;
	localparam [4:0] ST_STOP = 5'h10;

	// control fields
	reg mode_ff;
	reg mce_ff;
	reg ren_ff;
	reg tb8_ff;
	reg rb8_ff;
	reg ti_ff;
	reg ri_ff;
	reg [7:0] rx_latch_ff;
	reg [7:0] rdata_ff;
	reg int_ff;

	// transmit engine
	reg [4:0] tx_st_ff;
	reg [7:0] tx_shift_ff;
	reg [2:0] tx_cnt_ff;
	reg tx_half_ff;
	reg txd_ff;
	reg ti_set;

	// receive engine
	reg [4:0] rx_st_ff;
	reg [7:0] rx_shift_ff;
	reg [2:0] rx_cnt_ff;
	reg rx_phase_ff;
	reg rx_prev_ff;
	reg rx_ninth_ff;
	reg ri_set;
	reg rx_accept;
	wire rx_ovf;
	wire rx_start_edge;

	// fifo hookup
	wire fifo_in_valid;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire tx_pop;

	// software view of the control register after this cycle's write
	wire ctrl_hit;
	wire [7:0] ctrl_cur;
	reg [7:0] ctrl_sw;

	// one-bit mask for a bit select, used by bit writes
	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	assign SFR_RDATA_O = rdata_ff;
	assign SERIAL_OUT_PIN_O = txd_ff;
	assign INT_REQ_O = int_ff;
	assign TX_READY_O = fifo_in_ready;

	assign ctrl_hit = (SFR_ADDR_I == `UCB_ADDR_CTRL);
	assign ctrl_cur = {mode_ff, 1'b1, mce_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};

	// byte write replaces all bits; bit write touches exactly one bit
	always @*
	begin
		ctrl_sw = ctrl_cur;
		if (ctrl_hit & SFR_WR_I)
			ctrl_sw = SFR_WDATA_I;
		else if (ctrl_hit & SFR_BIT_WR_I)
		begin
			if (SFR_BIT_VAL_I)
				ctrl_sw = ctrl_cur | bit_mask(SFR_BIT_SEL_I);
			else
				ctrl_sw = ctrl_cur & ~bit_mask(SFR_BIT_SEL_I);
		end
	end

	// control register; hardware set of a flag wins over a software clear
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			mode_ff <= 1'b0;
			mce_ff <= 1'b0;
			ren_ff <= 1'b0;
			tb8_ff <= 1'b0;
			ti_ff <= 1'b0;
			ri_ff <= 1'b0;
		end
		else
		begin
			// bit 6 is not stored at all, so writes to it vanish
			mode_ff <= ctrl_sw[`UCB_BIT_MODE];
			mce_ff <= ctrl_sw[`UCB_BIT_MCE];
			ren_ff <= ctrl_sw[`UCB_BIT_REN];
			tb8_ff <= ctrl_sw[`UCB_BIT_TB8];
			ti_ff <= ti_set | ctrl_sw[`UCB_BIT_TI];
			ri_ff <= ri_set | ctrl_sw[`UCB_BIT_RI];
		end
	end

	// ninth receive bit: software may write it, an accepted frame overrides
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			rb8_ff <= 1'b0;
		else if (ri_set)
			rb8_ff <= rx_ninth_ff;
		else
			rb8_ff <= ctrl_sw[`UCB_BIT_RB8];
	end

	// read port; the transmit path has no read route at all
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			rdata_ff <= 8'h00;
		else if (SFR_RD_I)
		begin
			if (ctrl_hit)
				rdata_ff <= ctrl_cur;
			else if (SFR_ADDR_I == `UCB_ADDR_DATA)
				rdata_ff <= rx_latch_ff;
			else
				rdata_ff <= 8'h00;
		end
	end

	// interrupt request, one cycle behind the flags
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			int_ff <= 1'b0;
		else
			int_ff <= INT_EN_I & (ti_ff | ri_ff);
	end

	// writes to the data location queue bytes; a full queue refuses them
	assign fifo_in_valid = SFR_WR_I & (SFR_ADDR_I == `UCB_ADDR_DATA);
	assign tx_pop = tx_st_ff[0] & fifo_out_valid;

	ucb_fifo #(
		.WIDTH(`UCB_FIFO_WIDTH),
		.DEPTH(`UCB_FIFO_DEPTH),
		.AW(`UCB_FIFO_AW)
	) u_txq (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(SFR_WDATA_I),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(tx_pop),
		.out_data_o(fifo_out_data)
	);

	// transmit engine; a bit lasts two timer overflows
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			tx_st_ff <= ST_IDLE;
			tx_shift_ff <= 8'h00;
			tx_cnt_ff <= 3'h0;
			tx_half_ff <= 1'b0;
			txd_ff <= 1'b1;
			ti_set <= 1'b0;
		end
		else
		begin
			ti_set <= 1'b0;
			if (TX_OVF_I)
				tx_half_ff <= ~tx_half_ff;
			case (tx_st_ff)
				ST_IDLE:
				begin
					txd_ff <= 1'b1;
					if (fifo_out_valid)
					begin
						// start bit goes out at once, ahead of the next overflow pair
						tx_shift_ff <= fifo_out_data;
						tx_cnt_ff <= 3'h0;
						tx_half_ff <= 1'b0;
						txd_ff <= 1'b0;
						tx_st_ff <= ST_START;
					end
				end
				ST_START:
				begin
					if (TX_OVF_I & tx_half_ff)
					begin
						txd_ff <= tx_shift_ff[0];
						tx_st_ff <= ST_DATA;
					end
				end
				ST_DATA:
				begin
					if (TX_OVF_I & tx_half_ff)
					begin
						tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
						tx_cnt_ff <= tx_cnt_ff + 3'h1;
						if (tx_cnt_ff == `UCB_LAST_DATA_BIT)
						begin
							if (mode_ff)
							begin
								txd_ff <= tb8_ff;
								tx_st_ff <= ST_NINTH;
							end
							else
							begin
								txd_ff <= 1'b1;
								ti_set <= 1'b1;
								tx_st_ff <= ST_STOP;
							end
						end
						else
							txd_ff <= tx_shift_ff[1];
					end
				end
				ST_NINTH:
				begin
					if (TX_OVF_I & tx_half_ff)
					begin
						txd_ff <= 1'b1;
						ti_set <= 1'b1;
						tx_st_ff <= ST_STOP;
					end
				end
				ST_STOP:
				begin
					if (TX_OVF_I & tx_half_ff)
						tx_st_ff <= ST_IDLE;
				end
				default:
				begin
					txd_ff <= 1'b1;
					tx_st_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// falling edge on an idle, enabled line restarts the receive bit grid
	assign rx_start_edge = rx_st_ff[0] & ren_ff & rx_prev_ff & ~SERIAL_IN_PIN_I;

	ucb_rx_timer u_rxtmr (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.run_i(TMR_RUN_I),
		.tick_i(TMR_TICK_I),
		.reload_i(BAUD_RELOAD_VALUE_I),
		.force_reload_i(rx_start_edge),
		.ovf_o(rx_ovf)
	);

	// acceptance at the stop sample: flag clear and filter satisfied
	always @*
	begin
		rx_accept = ~ri_ff;
		if (mce_ff & mode_ff & ~rx_ninth_ff)
			rx_accept = 1'b0;
		if (mce_ff & ~mode_ff & ~SERIAL_IN_PIN_I)
			rx_accept = 1'b0;
	end

	// receive engine; first overflow after reload lands mid start bit
	always @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			rx_st_ff <= ST_IDLE;
			rx_shift_ff <= 8'h00;
			rx_cnt_ff <= 3'h0;
			rx_phase_ff <= 1'b0;
			rx_prev_ff <= 1'b1;
			rx_ninth_ff <= 1'b0;
			rx_latch_ff <= `UCB_DATA_RESET;
			ri_set <= 1'b0;
		end
		else
		begin
			rx_prev_ff <= SERIAL_IN_PIN_I;
			ri_set <= 1'b0;
			if (rx_ovf)
				rx_phase_ff <= ~rx_phase_ff;
			if (~ren_ff)
				rx_st_ff <= ST_IDLE;
			else
			begin
				case (rx_st_ff)
					ST_IDLE:
					begin
						if (rx_start_edge)
						begin
							rx_phase_ff <= 1'b0;
							rx_cnt_ff <= 3'h0;
							rx_st_ff <= ST_START;
						end
					end
					ST_START:
					begin
						// a line back high at mid start bit was a glitch
						if (rx_ovf & ~rx_phase_ff)
							rx_st_ff <= SERIAL_IN_PIN_I ? ST_IDLE : ST_DATA;
					end
					ST_DATA:
					begin
						if (rx_ovf & ~rx_phase_ff)
						begin
							rx_shift_ff <= {SERIAL_IN_PIN_I, rx_shift_ff[7:1]};
							rx_cnt_ff <= rx_cnt_ff + 3'h1;
							if (rx_cnt_ff == `UCB_LAST_DATA_BIT)
								rx_st_ff <= mode_ff ? ST_NINTH : ST_STOP;
						end
					end
					ST_NINTH:
					begin
						if (rx_ovf & ~rx_phase_ff)
						begin
							rx_ninth_ff <= SERIAL_IN_PIN_I;
							rx_st_ff <= ST_STOP;
						end
					end
					ST_STOP:
					begin
						if (rx_ovf & ~rx_phase_ff)
						begin
							// 8-bit frames keep the sampled stop level as the ninth bit
							if (~mode_ff)
								rx_ninth_ff <= SERIAL_IN_PIN_I;
							// overrun: a frame seen with the flag set is dropped
							if (rx_accept)
							begin
								rx_latch_ff <= rx_shift_ff;
								ri_set <= 1'b1;
							end
							rx_st_ff <= ST_IDLE;
						end
					end
					default:
						rx_st_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

//--- inc/ucb_consts.vh
// constants for the serial port control and data buffer block
// assumes an 8-bit special-function bus with byte and single-bit writes
`ifndef UCB_CONSTS_VH
`define UCB_CONSTS_VH

// special-function addresses
`define UCB_ADDR_CTRL 8'h98
`define UCB_ADDR_DATA 8'h99

// serial_port_control field positions
`define UCB_BIT_MODE 3'h7
`define UCB_BIT_ONE 3'h6
`define UCB_BIT_MCE 3'h5
`define UCB_BIT_REN 3'h4
`define UCB_BIT_TB8 3'h3
`define UCB_BIT_RB8 3'h2
`define UCB_BIT_TI 3'h1
`define UCB_BIT_RI 3'h0

// reset values
`define UCB_CTRL_RESET 8'h40
`define UCB_DATA_RESET 8'h00

// timing: baud timer overflows per bit, last data bit index
`define UCB_OVF_PER_BIT 2
`define UCB_LAST_DATA_BIT 3'h7
`define UCB_TIMER_TOP 8'hff

// transmit buffer shape
`define UCB_FIFO_WIDTH 8
`define UCB_FIFO_DEPTH 8
`define UCB_FIFO_AW 3

`endif

//--- src/ucb_fifo.v
// synchronous fifo that buffers bytes written for transmission
// assumes one clock and a synchronous active-high reset
`include "ucb_consts.vh"

module ucb_fifo #(
	parameter WIDTH = `UCB_FIFO_WIDTH,
	parameter DEPTH = `UCB_FIFO_DEPTH,
	parameter AW = `UCB_FIFO_AW
) (
	input wire clk_i,
	input wire rst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] cnt_ff;
	reg ready_ff;
	wire push;
	wire pop;
	reg [AW:0] nxt_cnt;

	// occupancy at which the queue refuses further bytes
	localparam [AW:0] FULL_CNT = DEPTH;

	// ready is a flop of its own so the top can show it without a gate
	assign in_ready_o = ready_ff;
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_ptr_ff];
	assign push = in_valid_i & ready_ff;
	assign pop = out_valid_o & out_ready_i;

	// occupancy after this cycle's push and pop
	always @*
	begin
		nxt_cnt = cnt_ff;
		if (push & ~pop)
			nxt_cnt = cnt_ff + 1'b1;
		else if (pop & ~push)
			nxt_cnt = cnt_ff - 1'b1;
	end

	// storage has no reset, only the pointers, count and ready flag do
	always @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data_i;
	end

	// pointers and ready flag kept as flops so ready never glitches
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			ready_ff <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			cnt_ff <= nxt_cnt;
			ready_ff <= (nxt_cnt != FULL_CNT);
		end
	end
endmodule

//--- src/ucb_rx_timer.v
// private copy of the 8-bit auto-reload baud timer used by the receiver
// assumes tick_i is the timer counting pulse shared with the transmit timer
`include "ucb_consts.vh"

module ucb_rx_timer (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	input wire tick_i,
	input wire [7:0] reload_i,
	input wire force_reload_i,
	output reg ovf_o
);
	reg [7:0] cnt_ff;

	// counts up from the reload value; a start edge restarts the bit grid
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_ff <= 8'h00;
			ovf_o <= 1'b0;
		end
		else if (force_reload_i)
		begin
			cnt_ff <= reload_i;
			ovf_o <= 1'b0;
		end
		else if (run_i & tick_i)
		begin
			if (cnt_ff == `UCB_TIMER_TOP)
			begin
				cnt_ff <= reload_i;
				ovf_o <= 1'b1;
			end
			else
			begin
				cnt_ff <= cnt_ff + 8'h01;
				ovf_o <= 1'b0;
			end
		end
		else
			ovf_o <= 1'b0;
	end
endmodule

//--- bench/ucb_assertions.sv
// checker for the serial port block, watching only its top ports
// assumes one clock domain and a synchronous active-high reset
`include "ucb_consts.vh"
module ucb_assertions (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_BIT_WR_I,
	input wire logic [2:0] SFR_BIT_SEL_I,
	input wire logic SFR_BIT_VAL_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic TX_OVF_I,
	input wire logic SERIAL_OUT_PIN_O,
	input wire logic INT_EN_I,
	input wire logic INT_REQ_O
);
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);
	// decoded helpers shared by several properties
	wire any_wr = SFR_WR_I | SFR_BIT_WR_I;
	wire ctrl_sel = SFR_ADDR_I == `UCB_ADDR_CTRL;
	// software sets the receive flag, enable still high a cycle later
	sequence flag_set;
		SFR_BIT_WR_I && !SFR_WR_I && ctrl_sel && SFR_BIT_SEL_I == 3'h0 && SFR_BIT_VAL_I ##1 INT_EN_I;
	endsequence
	sequence line_fall;
		$fell(SERIAL_OUT_PIN_O);
	endsequence
	reset_idle_a: assert property (disable iff (1'b0) RST_I |=> SERIAL_OUT_PIN_O && !INT_REQ_O)
		else $error("outputs not idle after reset");
	int_gate_a: assert property (!INT_EN_I |=> !INT_REQ_O)
		else $error("request while disabled");
	int_set_a: assert property (flag_set |=> INT_REQ_O)
		else $error("flag set gave no request");
	int_hold_a: assert property (INT_REQ_O && INT_EN_I && !any_wr && !$past(any_wr) |=> INT_REQ_O)
		else $error("request dropped without a clear");
	tx_edge_a: assert property ($rose(SERIAL_OUT_PIN_O) |-> $past(TX_OVF_I) || $past(RST_I))
		else $error("line rose off a baud boundary");
	low_len_a: assert property (line_fall |-> !SERIAL_OUT_PIN_O [*8])
		else $error("low bit too short");
	rd_hold_a: assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
		else $error("read data moved without a read");
	rd_unmapped_a: assert property (SFR_RD_I && !ctrl_sel && SFR_ADDR_I != `UCB_ADDR_DATA |=> SFR_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	bit6_read_a: assert property (SFR_RD_I && ctrl_sel |=> SFR_RDATA_O[`UCB_BIT_ONE])
		else $error("control bit 6 read as zero");
endmodule
bind ucb_uart0 ucb_assertions u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SFR_ADDR_I(SFR_ADDR_I),
	.SFR_WR_I(SFR_WR_I), .SFR_BIT_WR_I(SFR_BIT_WR_I), .SFR_BIT_SEL_I(SFR_BIT_SEL_I),
	.SFR_BIT_VAL_I(SFR_BIT_VAL_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O), .TX_OVF_I(TX_OVF_I),
	.SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .INT_EN_I(INT_EN_I), .INT_REQ_O(INT_REQ_O));

//--- bench/ucb_peer.sv
// remote serial peer: frames onto the receive line, decodes the transmit line
// assumes a bit time of BIT system clock cycles and idle-high lines
module ucb_peer #(
	parameter int BIT = 16
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o = 1'b1,
	output logic got_o = 1'b0,
	output logic [8:0] word_o = 9'h000
);
	// start bit first, then lsb first, one bit time each, then idle high
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			line_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
		line_o <= 1'b1;
	endtask
	// sampling 20 cycles into the frame tolerates a start bit cut short to the
	// next overflow pair; the last bit is not waited out, so back-to-back frames are caught
	initial
		forever
		begin
			@(negedge line_i);
			for (int i = 0; i < 9; i++)
			begin
				repeat (i == 0 ? 20 : BIT) @(posedge clk_i);
				word_o[i] <= line_i;
			end
			got_o <= 1'b1;
			@(posedge clk_i);
			got_o <= 1'b0;
		end
endmodule

//--- bench/tb.sv
// bench top: drives the register bus and baud overflow, checks through queues
// assumes the peer model on the serial lines and the checker bound in its file
`include "ucb_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ca = `UCB_ADDR_CTRL;
	localparam logic [7:0] da = `UCB_ADDR_DATA;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, bwr = 1'b0, rd = 1'b0, bval = 1'b0, ovf = 1'b0;
	logic ien = 1'b0, rd_seen = 1'b0, txo, rxi, rdy, irq, got, ri, rb;
	logic [2:0] bsel = 3'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, lat = 8'h00, rdata, b;
	logic [8:0] word;
	logic [7:0] rd_q[$];
	logic [8:0] tx_q[$];
	// reception cases: {keep flag, enable, filter, mode, stop, ninth}
	logic [5:0] cs [8] = '{6'h12, 6'h18, 6'h10, 6'h1e, 6'h1f, 6'h16, 6'h37, 6'h02};
	int mismatches = 0, compares = 0, seed = 55790, oc = 0;
	ucb_uart0 dut (.SYS_CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_WDATA_I(wdata),
		.SFR_BIT_WR_I(bwr), .SFR_BIT_SEL_I(bsel), .SFR_BIT_VAL_I(bval), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
		.TX_READY_O(rdy), .TMR_RUN_I(1'b1), .TMR_TICK_I(1'b1), .TX_OVF_I(ovf), .BAUD_RELOAD_VALUE_I(8'hf8),
		.SERIAL_IN_PIN_I(rxi), .SERIAL_OUT_PIN_O(txo), .INT_EN_I(ien), .INT_REQ_O(irq));
	ucb_peer peer (.clk_i(clk), .line_i(txo), .line_o(rxi), .got_o(got), .word_o(word));
	// 20 MHz system clock
	always #25 clk = ~clk;
	// overflow every 8 cycles, the same period reload 0xf8 gives the receive copy
	always @(posedge clk)
	begin
		oc <= oc + 1;
		ovf <= #1 (oc % 8 == 7);
	end
	// read data lands a cycle after the read edge; frames come from the peer
	always @(posedge clk)
	begin
		if (rd_seen)
			chk({1'b0, rdata}, {1'b0, rd_q.pop_front()});
		if (got)
			chk(word, tx_q.pop_front());
		rd_seen <= rd;
	end
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// k: 1 byte write, 2 read, 3 bit write of d[0] at d[3:1]; idle cycle after
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] k);
		addr <= a;
		wdata <= d;
		bsel <= d[3:1];
		bval <= d[0];
		wr <= k == 2'h1;
		rd <= k == 2'h2;
		bwr <= k == 2'h3;
		@(posedge clk);
		#1;
		{wr, rd, bwr} <= 3'h0;
		@(posedge clk);
		#1;
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		acc(a, 8'h00, 2'h2);
	endtask
	// bounded wait for all queued frames, then 24 cycles, a bit and a half
	task automatic drain();
		for (int i = 0; i < 4000 && tx_q.size() != 0; i++)
			@(posedge clk);
		if (tx_q.size() != 0)
		begin
			mismatches++;
			end_of_test();
		end
		repeat (24) @(posedge clk);
		#1;
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		rst <= 1'b0;
		rdx(ca, `UCB_CTRL_RESET);
		rdx(da, `UCB_DATA_RESET);
		rdx(8'h9a, 8'h00);
		ien <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			acc(ca, {4'h0, i[2:0], 1'b1}, 2'h3);
			rdx(ca, 8'h40 | (8'h01 << i));
			acc(ca, {4'h0, i[2:0], 1'b0}, 2'h3);
			rdx(ca, 8'h40);
		end
		acc(ca, 8'hbf, 2'h1);
		rdx(ca, 8'hff);
		// fill the queue until it refuses, then one write that must be dropped
		for (int m = 0; m < 2; m++)
		begin
			acc(ca, {m[0], 3'b001, !m[0], 3'b000}, 2'h1);
			for (int k = 0; k < 12 && rdy === 1'b1; k++)
			begin
				b = $random(seed);
				tx_q.push_back({!m[0], b});
				acc(da, b, 2'h1);
			end
			chk({8'h00, rdy}, 9'h000);
			acc(da, 8'h5a, 2'h1);
			drain();
			rdx(ca, {m[0], 3'b101, !m[0], 3'b010});
		end
		ri = 1'b0;
		rb = 1'b0;
		for (int j = 0; j < 8; j++)
		begin
			if (!cs[j][5])
			begin
				acc(ca, {cs[j][2], 1'b0, cs[j][3], cs[j][4], 4'h0}, 2'h1);
				ri = 1'b0;
				rb = 1'b0;
			end
			b = $random(seed);
			peer.send(cs[j][2] ? {cs[j][1:0], b, 1'b0} : {1'b1, cs[j][1], b, 1'b0}, 10 + cs[j][2]);
			// accepted only when enabled, flag clear and filter satisfied
			if (cs[j][4] && !ri && !(cs[j][3] && !(cs[j][2] ? cs[j][0] : cs[j][1])))
			begin
				lat = b;
				rb = cs[j][2] ? cs[j][0] : cs[j][1];
				ri = 1'b1;
			end
			repeat (4) @(posedge clk);
			#1;
			rdx(da, lat);
			rdx(ca, {cs[j][2], 1'b1, cs[j][3], cs[j][4], 1'b0, rb, 1'b0, ri});
		end
		end_of_test();
	end
endmodule
